// ==== src/cbsc_pkg.sv ====
package cbsc_pkg;

  // ------------------------------------------------------------
  // Machine cycle kinds requested by the core.
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CBSC_K_WRITE = 2'b00,  // Memory or I/O write.
    CBSC_K_READ  = 2'b01,  // Memory or I/O read.
    CBSC_K_FETCH = 2'b10,  // Opcode fetch.
    CBSC_K_IDLE  = 2'b11   // Internal cycle of double_add_instruction.
  } cbsc_kind_t;

  // Bus state machine states.
  typedef enum logic [2:0] {
    CBSC_S_IDLE = 3'b000,
    CBSC_S_T1   = 3'b001,
    CBSC_S_T2   = 3'b010,
    CBSC_S_TW   = 3'b011,
    CBSC_S_T3   = 3'b100,
    CBSC_S_HOLD = 3'b101
  } cbsc_state_t;

  // One machine cycle request from the core.
  typedef struct packed {
    logic       valid;  // Request present.
    cbsc_kind_t kind;   // Cycle kind.
    logic       io;     // High for I/O space.
    logic [15:0] addr;  // Full address.
    logic [7:0] wdata;  // Write data.
  } cbsc_req_t;

  // Accepted interrupt handed to the core.
  typedef struct packed {
    logic       take;     // One-cycle accept pulse.
    logic       general;  // General request: core fetches the vector.
    logic [7:0] vec;      // Restart address for internal restarts.
  } cbsc_irq_t;

  // ------------------------------------------------------------
  // Status codes {high, low} and restart addresses.
  // ------------------------------------------------------------
  localparam logic [1:0] CBSC_ST_HALT  = 2'b00;
  localparam logic [1:0] CBSC_ST_WRITE = 2'b01;
  localparam logic [1:0] CBSC_ST_READ  = 2'b10;
  localparam logic [1:0] CBSC_ST_FETCH = 2'b11;
  localparam logic [7:0] CBSC_VEC_TRAP = 8'h24;
  localparam logic [7:0] CBSC_VEC_LOW  = 8'h2C;
  localparam logic [7:0] CBSC_VEC_MID  = 8'h34;
  localparam logic [7:0] CBSC_VEC_EDGE = 8'h3C;

  // Set-mask data bit positions and reset values.
  localparam int CBSC_SIM_SOD     = 7;
  localparam int CBSC_SIM_SOD_EN  = 6;
  localparam int CBSC_SIM_CLR_EDG = 4;
  localparam int CBSC_SIM_MSK_EN  = 3;
  localparam logic [2:0] CBSC_MASK_RST = 3'h7;
  localparam int CBSC_RESET_MIN_CYC = 3;

endpackage

// ==== src/cbsc_top.sv ====
// Functional notes
// - Upper byte address only; lower byte shared.
// - Low address and strobe in first state.
// - Second and third states carry data.
// - Address strobe low in bus-idle cycles.
// - Status codes halt/write/read/fetch as listed.
// - High status bit valid early for direction.
// - Space-select shows memory or I/O.
// - Active-low read and write strobes.
// - Ready low inserts wait states.
// - Hold releases buses after current cycle.
// - Grant one cycle before release; resume after.
// - Released pins keep their last level.
// - Halt stops core clock, keeps output clock; this design has no clock output.
// - Reset or interrupt input wakes power-down.
// - Reset held three cycles clears flags.
// - Reset output synchronous, active in reset.
// - Serial out changes by set-mask; high at reset.
// - Read-mask copies serial input to bit 7.
// - General request sampled in last instruction state.
// - Enable set/cleared by software, cleared on accept.
// - Acknowledge strobe replaces read after general accept.
// - Priority trap, edge, mid, low, general.
// - Hold, ready, interrupts synchronised first.
// - Restart addresses 24, 2C, 34, 3C.
// - Edge restart latched until serviced or cleared.
// - Trap needs edge and level, rearms on low.
module cbsc_top
  import cbsc_pkg::*;
(
  input  wire logic       REF_CLK,                // System clock, 100 MHz.
  input  wire logic       SRST,                   // Synchronous reset, active high.
  input  wire logic       RESET_IN_N,             // Reset pin, active low.
  input  wire logic       READY,                  // Ready pin.
  input  wire logic       HOLD,                   // Hold request pin.
  input  wire logic       TRAP,                   // Non-maskable request pin.
  input  wire logic       RESTART_IRQ_EDGE,       // Edge restart pin.
  input  wire logic       RESTART_IRQ_MID,        // Mid restart pin.
  input  wire logic       RESTART_IRQ_LOW,        // Low restart pin.
  input  wire logic       GENERAL_IRQ,            // General request pin.
  input  wire logic       SERIAL_IN_LINE,         // Serial input pin.
  input  wire logic [7:0] SHARED_ADDR_DATA_BUS_I, // Shared bus, pin level.
  output logic      [7:0] SHARED_ADDR_DATA_BUS_O, // Shared bus, driven value.
  output logic            SHARED_ADDR_DATA_BUS_OE,// Shared bus enable.
  output logic      [7:0] UPPER_ADDRESS_BUS,      // Upper address byte.
  output logic            CTL_OE,                 // Enable of upper bus and strobes.
  output logic            ADDR_STROBE,            // Address latch strobe.
  output logic            CYCLE_STATUS_HIGH,      // Status high bit.
  output logic            CYCLE_STATUS_LOW,       // Status low bit.
  output logic            SPACE_IO,               // High for I/O, low for memory.
  output logic            READ_N,                 // Read strobe, active low.
  output logic            WRITE_N,                // Write strobe, active low.
  output logic            IRQ_ACK_N,              // Interrupt acknowledge, active low.
  output logic            BUS_GRANT,              // Hold acknowledge.
  output logic            RESET_OUT,              // System reset out.
  output logic            SERIAL_OUT_LINE,        // Serial output pin.
  output logic            PWR_DOWN,               // Stops the core clock.
  input  cbsc_pkg::cbsc_req_t CORE_REQ,           // Machine cycle request.
  output logic            CORE_TAKEN,             // Request accepted pulse.
  output logic            CORE_DONE,              // Cycle finished pulse.
  output logic      [7:0] CORE_RDATA,             // Read data.
  input  wire logic       CORE_INSTR_END,         // Last state of instruction.
  input  wire logic       CORE_HALT,              // Halt executed.
  input  wire logic       CORE_EI,                // Enable interrupts.
  input  wire logic       CORE_DI,                // Disable interrupts.
  input  wire logic       CORE_SIM,               // Set-mask executed.
  input  wire logic [7:0] CORE_SIM_DATA,          // Set-mask operand.
  input  wire logic       CORE_RIM,               // read_mask_instruction executed.
  output logic      [7:0] RIM_DATA,               // Read-mask result.
  output cbsc_pkg::cbsc_irq_t IRQ                 // Accepted interrupt.
);

  // ------------------------------------------------------------
  // Input synchronisers.
  // ------------------------------------------------------------
  localparam int NS = 17;
  logic [NS-1:0] pin_in;   // Raw pin levels.
  logic [NS-1:0] meta_ff;  // First stage, read only by second.
  logic [NS-1:0] sync_ff;  // Safe levels.

  assign pin_in = {SHARED_ADDR_DATA_BUS_I, SERIAL_IN_LINE, GENERAL_IRQ, RESTART_IRQ_LOW,
                   RESTART_IRQ_MID, RESTART_IRQ_EDGE, TRAP, HOLD, READY, RESET_IN_N};

  // Two flops on every pin before any logic looks at it.
  always_ff @(posedge REF_CLK)
  begin
    meta_ff <= pin_in;
    sync_ff <= meta_ff;
  end

  wire       rstin_s = sync_ff[0];  // Reset pin, active low.
  wire       rdy_s   = sync_ff[1];
  wire       hold_s  = sync_ff[2];
  wire       trap_s  = sync_ff[3];
  wire       edg_s   = sync_ff[4];
  wire       mid_s   = sync_ff[5];
  wire       low_s   = sync_ff[6];
  wire       gen_s   = sync_ff[7];
  wire       sid_s   = sync_ff[8];
  wire [7:0] data_s  = sync_ff[16:9];
  wire       in_rst  = SRST || !rstin_s;  // Reset mode.

  // Read data is the second synchroniser stage itself: in the cycle in which
  // CORE_DONE stands it holds the level the target drove while the read
  // strobe was low. A further capture flop would see the data one edge too late.
  assign CORE_RDATA = data_s;

  // ------------------------------------------------------------
  // Bus state machine.
  // ------------------------------------------------------------
  cbsc_state_t st_ff;    // Current state.
  cbsc_state_t nxt_st;   // Next state.
  cbsc_req_t   cyc_ff;   // Latched request.
  logic        pd_ff;    // Power-down.
  logic        irq_ack_n_ff;  // Acknowledge instruction in progress.
  logic        ie_ff;        // General enable.
  logic [2:0]  mask_ff;      // Masks {edge, mid, low}.
  logic        edg_prev_ff;  // Edge input delayed.
  logic        edg_pend_ff;  // Latched edge request.
  logic        trap_prev_ff; // Trap input delayed.
  logic        trap_arm_ff;  // Trap edge seen, not yet taken.

  wire       take    = CORE_REQ.valid && st_ff == CBSC_S_IDLE && !hold_s && !pd_ff && !in_rst;
  cbsc_req_t nxt_cyc;
  assign nxt_cyc     = take ? CORE_REQ : cyc_ff;
  wire       is_xfer = nxt_cyc.kind != CBSC_K_IDLE;
  wire       is_wr   = nxt_cyc.kind == CBSC_K_WRITE;

  // Next state: three states, a wait per low ready, hold at cycle end.
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      CBSC_S_IDLE: if (in_rst) nxt_st = CBSC_S_IDLE;
                   else if (hold_s) nxt_st = CBSC_S_HOLD;
                   else if (take) nxt_st = CBSC_S_T1;
      CBSC_S_T1:   nxt_st = CBSC_S_T2;
      // Ready low during a transfer stretches the cycle.
      CBSC_S_T2:   nxt_st = (is_xfer && !rdy_s) ? CBSC_S_TW : CBSC_S_T3;
      CBSC_S_TW:   nxt_st = rdy_s ? CBSC_S_T3 : CBSC_S_TW;
      // Hold is honoured only once the current cycle ends.
      CBSC_S_T3:   nxt_st = hold_s ? CBSC_S_HOLD : CBSC_S_IDLE;
      CBSC_S_HOLD: nxt_st = (hold_s && !in_rst) ? CBSC_S_HOLD : CBSC_S_IDLE;
      default:     nxt_st = CBSC_S_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Registered pin values derived from the next state; the control enable comes from the current state.
  // ------------------------------------------------------------
  wire n_t1   = nxt_st == CBSC_S_T1;
  wire n_data = nxt_st == CBSC_S_T2 || nxt_st == CBSC_S_TW || nxt_st == CBSC_S_T3;
  wire n_strb = (nxt_st == CBSC_S_T2 || nxt_st == CBSC_S_TW) && is_xfer;
  // Buses drop one cycle after grant rises and return one after it falls.
  wire n_oe   = st_ff != CBSC_S_HOLD && !pd_ff && !in_rst;
  wire [1:0] n_stat = pd_ff ? CBSC_ST_HALT :
                      nxt_cyc.kind == CBSC_K_WRITE ? CBSC_ST_WRITE :
                      nxt_cyc.kind == CBSC_K_FETCH ? CBSC_ST_FETCH : CBSC_ST_READ;
  wire n_rd   = n_strb && !is_wr;

  // Pin flops; when released they keep their last value, which models
  // the weak keeper since this file holds no three-state drivers.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      st_ff <= CBSC_S_IDLE;
      cyc_ff <= '0;
      SHARED_ADDR_DATA_BUS_O <= 8'h00;
      SHARED_ADDR_DATA_BUS_OE <= 1'b0;
      UPPER_ADDRESS_BUS <= 8'h00;
      CTL_OE <= 1'b0;
      ADDR_STROBE <= 1'b0;
      {CYCLE_STATUS_HIGH, CYCLE_STATUS_LOW} <= CBSC_ST_HALT;
      SPACE_IO <= 1'b0;
      READ_N <= 1'b1;
      WRITE_N <= 1'b1;
      IRQ_ACK_N <= 1'b1;
      BUS_GRANT <= 1'b0;
      CORE_TAKEN <= 1'b0;
      CORE_DONE <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cyc_ff <= nxt_cyc;
      BUS_GRANT <= nxt_st == CBSC_S_HOLD;
      CTL_OE <= n_oe;
      SHARED_ADDR_DATA_BUS_OE <= n_oe && (n_t1 || (n_data && is_wr && is_xfer));
      if (n_t1)
      begin
        UPPER_ADDRESS_BUS <= nxt_cyc.addr[15:8];
        SHARED_ADDR_DATA_BUS_O <= nxt_cyc.addr[7:0];
        SPACE_IO <= nxt_cyc.io;
      end
      else if (n_data && is_wr)
        SHARED_ADDR_DATA_BUS_O <= nxt_cyc.wdata;
      // Strobe only for real transfers, so it stays low on idle cycles.
      ADDR_STROBE <= n_t1 && is_xfer;
      // Status appears with the strobe, ahead of the read or write strobe.
      if (n_t1 || pd_ff)
        {CYCLE_STATUS_HIGH, CYCLE_STATUS_LOW} <= n_stat;
      READ_N <= !(n_rd && !irq_ack_n_ff);
      IRQ_ACK_N <= !(n_rd && irq_ack_n_ff);
      WRITE_N <= !(n_strb && is_wr);
      CORE_TAKEN <= take;
      CORE_DONE <= st_ff == CBSC_S_T3;
    end
  end

  // ------------------------------------------------------------
  // Reset mode, power-down and serial lines.
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    RESET_OUT <= in_rst;
    PWR_DOWN <= pd_ff;
    if (in_rst)
    begin
      pd_ff <= 1'b0;
      SERIAL_OUT_LINE <= 1'b1;
      RIM_DATA <= 8'h00;
    end
    else
    begin
      // Any request pin restarts the clock, masked or not.
      if (trap_s || edg_s || mid_s || low_s || gen_s)
        pd_ff <= 1'b0;
      else if (CORE_HALT && st_ff == CBSC_S_IDLE)
        pd_ff <= 1'b1;
      if (CORE_SIM && CORE_SIM_DATA[CBSC_SIM_SOD_EN])
        SERIAL_OUT_LINE <= CORE_SIM_DATA[CBSC_SIM_SOD];
      if (CORE_RIM)
        RIM_DATA <= {sid_s, edg_pend_ff, mid_s, low_s, ie_ff, mask_ff};
    end
  end

  // ------------------------------------------------------------
  // Interrupt recognition and priority.
  // ------------------------------------------------------------

  wire trap_req = trap_arm_ff && trap_s;
  wire edg_req  = ie_ff && edg_pend_ff && !mask_ff[2];
  wire mid_req  = ie_ff && mid_s && !mask_ff[1];
  wire low_req  = ie_ff && low_s && !mask_ff[0];
  wire gen_req  = ie_ff && gen_s;
  wire accept   = CORE_INSTR_END && !in_rst &&
                  (trap_req || edg_req || mid_req || low_req || gen_req);
  // Fixed priority, trap first and general last.
  wire [7:0] vec = trap_req ? CBSC_VEC_TRAP : edg_req ? CBSC_VEC_EDGE :
                   mid_req ? CBSC_VEC_MID : CBSC_VEC_LOW;
  wire gen_win  = !(trap_req || edg_req || mid_req || low_req);
  wire edg_rise = edg_s && !edg_prev_ff;
  wire edg_ack  = accept && !trap_req && edg_req;
  wire trap_ack = accept && trap_req;

  // Flags; a fresh edge wins over a clear in the same cycle.
  always_ff @(posedge REF_CLK)
  begin
    edg_prev_ff <= edg_s;
    trap_prev_ff <= trap_s;
    if (in_rst)
    begin
      ie_ff <= 1'b0;
      mask_ff <= CBSC_MASK_RST;
      edg_pend_ff <= 1'b0;
      trap_arm_ff <= 1'b0;
      irq_ack_n_ff <= 1'b0;
      IRQ <= '0;
    end
    else
    begin
      if (accept)
        ie_ff <= 1'b0;
      else if (CORE_EI)
        ie_ff <= 1'b1;
      else if (CORE_DI)
        ie_ff <= 1'b0;
      if (CORE_SIM && CORE_SIM_DATA[CBSC_SIM_MSK_EN])
        mask_ff <= CORE_SIM_DATA[2:0];
      // Latched even while masked or disabled.
      if (edg_rise)
        edg_pend_ff <= 1'b1;
      else if (edg_ack || (CORE_SIM && CORE_SIM_DATA[CBSC_SIM_CLR_EDG]))
        edg_pend_ff <= 1'b0;
      // Trap rearms only on a new rising edge.
      if (trap_s && !trap_prev_ff)
        trap_arm_ff <= 1'b1;
      else if (trap_ack)
        trap_arm_ff <= 1'b0;
      // Acknowledge mode lasts until the acknowledge instruction ends.
      if (accept && gen_win)
        irq_ack_n_ff <= 1'b1;
      else if (CORE_INSTR_END)
        irq_ack_n_ff <= 1'b0;
      IRQ.take <= accept;
      IRQ.general <= accept && gen_win;
      IRQ.vec <= vec;
    end
  end

  // ------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  a_strobe_first: assert property (ADDR_STROBE |-> st_ff == CBSC_S_T1 && !READ_N == 1'b0)
    else $error("Address strobe outside first state.");
  a_idle_no_strobe: assert property (st_ff == CBSC_S_T1 && cyc_ff.kind == CBSC_K_IDLE |-> !ADDR_STROBE)
    else $error("Address strobe in idle cycle.");
  a_status_write: assert property (ADDR_STROBE && cyc_ff.kind == CBSC_K_WRITE |->
    {CYCLE_STATUS_HIGH, CYCLE_STATUS_LOW} == 2'b01 ##1 !WRITE_N)
    else $error("Write status or strobe wrong.");
  a_wait_hold: assert property (st_ff == CBSC_S_TW && !rdy_s |=> st_ff == CBSC_S_TW)
    else $error("Wait state left with ready low.");
  a_read_len: assert property ($rose(ADDR_STROBE) && rdy_s && cyc_ff.kind == CBSC_K_READ
    |=> $fell(READ_N) || !IRQ_ACK_N ##1 st_ff != CBSC_S_T1)
    else $error("Read cycle shape wrong.");
  a_grant_release: assert property ($rose(BUS_GRANT) |-> CTL_OE ##1 !CTL_OE)
    else $error("Release not one cycle after grant.");
  a_grant_resume: assert property ($fell(BUS_GRANT) && !pd_ff && !in_rst |-> !CTL_OE ##1 CTL_OE)
    else $error("Resume not one cycle after grant drop.");
  a_sod_reset: assert property (in_rst |=> SERIAL_OUT_LINE && RESET_OUT)
    else $error("Serial out or reset out wrong in reset.");
  a_accept_clears: assert property (IRQ.take |-> !ie_ff)
    else $error("Enable still set after accept.");
  a_ack_not_read: assert property (!IRQ_ACK_N |-> READ_N && irq_ack_n_ff)
    else $error("Read strobe during acknowledge.");
  a_trap_once: assert property (trap_ack ##1 trap_s [*2] |-> !trap_arm_ff)
    else $error("Trap rearmed without a low level.");
  a_wake_up: assert property (pd_ff && (trap_s || gen_s) |=> !pd_ff)
    else $error("Power-down not left on request.");

  c_hold: cover property ($rose(BUS_GRANT) ##[1:20] $fell(BUS_GRANT));
  c_wait: cover property (st_ff == CBSC_S_TW ##1 st_ff == CBSC_S_T3);
  c_gen_ack: cover property (IRQ.general ##[1:30] !IRQ_ACK_N);
  c_halt: cover property ($rose(pd_ff) ##[1:50] $fell(pd_ff));

endmodule

// ==== verification/cbsc_mem_model.sv ====
// ----------------------------------------------------------
// Memory and I/O target on the shared bus, with a keeper.
// ----------------------------------------------------------
module cbsc_mem_model
  import cbsc_pkg::*;
(
  input  wire logic       clk,     // Bus clock.
  input  wire logic       strobe,  // Address latch strobe.
  input  wire logic [7:0] bus_o,   // Value the device drives.
  input  wire logic       bus_oe,  // Device drive enable.
  input  wire logic       io,      // Space select.
  input  wire logic       rd_n,    // Read strobe.
  input  wire logic       wr_n,    // Write strobe.
  input  wire logic       ack_n,   // Acknowledge strobe.
  input  wire logic [3:0] wait_n,  // Stall length, zero for prompt.
  output logic      [7:0] pin,     // Resolved bus level.
  output logic            ready,   // Ready pin.
  output logic      [8:0] lat      // Latched space and low address.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [512];                // Memory cells, then I/O cells.
  logic [7:0] kept   = 8'h00;           // Keeper level.
  logic [3:0] stall  = 4'h0;            // Ready-low cycles left.
  logic       wr_q   = 1'b1;            // Write strobe one cycle late.
  wire        rd_on  = !rd_n || !ack_n; // Target drives the bus.
  // A known pattern lets the bench predict untouched cells.
  initial
  begin
    lat = 9'h000;
    for (int i = 0; i < 512; i++)
      mem[i] = i[7:0] ^ 8'h5A;
  end
  // A released bus keeps its last level rather than a lucky guess.
  assign pin   = bus_oe ? bus_o : (rd_on ? mem[lat] : kept);
  assign ready = (stall == 4'h0);
  // Ready is held low ahead of a slow access because the device sees it late.
  always @(posedge clk)
  begin
    kept <= pin;
    wr_q <= wr_n;
    if (strobe)
      lat <= {io, pin};
    if (!wr_n && wr_q)
      mem[lat] <= pin;
    stall <= (rd_on || !wr_n) ? stall - {3'h0, stall != 4'h0} : wait_n;
  end
endmodule

// ==== verification/tb_cbsc_top.sv ====
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
`define WAIT_FOR(c, lim) \
  begin \
    n = 0; \
    while (!(c) && n < lim) \
    begin \
      @(negedge ref_clk); \
      n++; \
    end \
  end
module tb_cbsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cbsc_pkg::*;
  // ----------------------------------------------------------
  // Stimulus, observed pins and bookkeeping.
  // ----------------------------------------------------------
  logic ref_clk = 1'b0, srst = 1'b1, rst_in_n = 1'b1, hold = 1'b0, trap = 1'b0, serial_in_line = 1'b0;
  logic irq_edge = 1'b0, irq_mid = 1'b0, irq_low = 1'b0, gen_irq = 1'b0, instr_end = 1'b0;
  logic halt = 1'b0, ei = 1'b0, di = 1'b0, sim = 1'b0, read_mask_instruction = 1'b0, ready, strobe, st_h, st_l, space_io;
  logic read_n, write_n, ack_n, grant, reset_out, serial_out_line, pwr_down, taken, done, bus_oe, ctl_oe;
  logic [7:0] sim_data = 8'h00, bus_i, bus_o, upper, rdata, rim_data;
  logic [8:0] lat;                    // Address the target latched.
  logic [3:0] mem_wait = 4'h0;        // Target stall length.
  cbsc_req_t  core_req = '0;          // Core cycle request.
  cbsc_irq_t  irq;                    // Accepted interrupt.
  int         miscompares = 0, check_count = 0, n, cycles = 0;
  always #5 ref_clk = ~ref_clk;
  cbsc_top i_cbsc_top (.REF_CLK(ref_clk), .SRST(srst), .RESET_IN_N(rst_in_n), .READY(ready),
    .HOLD(hold), .TRAP(trap), .RESTART_IRQ_EDGE(irq_edge), .RESTART_IRQ_MID(irq_mid),
    .RESTART_IRQ_LOW(irq_low), .GENERAL_IRQ(gen_irq), .SERIAL_IN_LINE(serial_in_line),
    .SHARED_ADDR_DATA_BUS_I(bus_i), .SHARED_ADDR_DATA_BUS_O(bus_o), .SHARED_ADDR_DATA_BUS_OE(bus_oe),
    .UPPER_ADDRESS_BUS(upper), .CTL_OE(ctl_oe), .ADDR_STROBE(strobe), .CYCLE_STATUS_HIGH(st_h),
    .CYCLE_STATUS_LOW(st_l), .SPACE_IO(space_io), .READ_N(read_n), .WRITE_N(write_n),
    .IRQ_ACK_N(ack_n), .BUS_GRANT(grant), .RESET_OUT(reset_out), .SERIAL_OUT_LINE(serial_out_line),
    .PWR_DOWN(pwr_down), .CORE_REQ(core_req), .CORE_TAKEN(taken), .CORE_DONE(done),
    .CORE_RDATA(rdata), .CORE_INSTR_END(instr_end), .CORE_HALT(halt), .CORE_EI(ei), .CORE_DI(di),
    .CORE_SIM(sim), .CORE_SIM_DATA(sim_data), .CORE_RIM(read_mask_instruction), .RIM_DATA(rim_data), .IRQ(irq));
  cbsc_mem_model i_cbsc_mem_model (.clk(ref_clk), .strobe(strobe), .bus_o(bus_o), .bus_oe(bus_oe),
    .io(space_io), .rd_n(read_n), .wr_n(write_n), .ack_n(ack_n), .wait_n(mem_wait), .pin(bus_i),
    .ready(ready), .lat(lat));
  // ----------------------------------------------------------
  // Shared bus cycles and pulses.
  // ----------------------------------------------------------
  task automatic bus_op(input cbsc_kind_t k, input logic io, input logic [15:0] a,
                        input logic [7:0] wd, input logic ack, input logic [7:0] exp_rd);
    int         len;
    logic [2:0] seen;
    logic [1:0] st;
    len  = 0;
    seen = 3'h0;
    st   = (k == CBSC_K_WRITE) ? CBSC_ST_WRITE : (k == CBSC_K_FETCH) ? CBSC_ST_FETCH : CBSC_ST_READ;
    core_req = '{1'b1, k, io, a, wd};
    @(negedge ref_clk);
    `WAIT_FOR(taken === 1'b1, 20)
    core_req.valid = 1'b0;
    `CHK("strobe", k != CBSC_K_IDLE, strobe)
    `CHK("status", st, {st_h, st_l})
    `CHK("space", io, space_io)
    `CHK("upper", a[15:8], upper)
    if (k != CBSC_K_IDLE)
      `CHK("low addr", {1'b1, a[7:0]}, {bus_oe, bus_o})
    while (done !== 1'b1 && len < 40)
    begin
      @(negedge ref_clk);
      len++;
      seen |= {!read_n, !write_n, !ack_n};
      if (!write_n)
        `CHK("wdata", {1'b1, wd}, {bus_oe, bus_o})
    end
    `CHK("strobes", (k == CBSC_K_WRITE) ? 3'h2 : (k == CBSC_K_IDLE) ? 3'h0 : ack ? 3'h1 : 3'h4, seen)
    if (mem_wait == 4'h0)
      `CHK("length", 3, len)
    else
      `CHK("waited", 1'b1, len >= 3 + mem_wait)
    if (k == CBSC_K_READ || k == CBSC_K_FETCH)
      `CHK("rdata", exp_rd, rdata)
    if (k != CBSC_K_IDLE)
      `CHK("latched", {io, a[7:0]}, lat)
  endtask
  task automatic pulse_sim(input logic [7:0] d);
    sim      = 1'b1;
    sim_data = d;
    @(negedge ref_clk);
    sim = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic irq_step(input logic en, input logic tk, input logic [7:0] vec, input logic gen);
    repeat (3) @(negedge ref_clk);
    ei = en;
    @(negedge ref_clk);
    ei        = 1'b0;
    instr_end = 1'b1;
    `CHK("early take", 1'b0, irq.take)
    @(negedge ref_clk);
    instr_end = 1'b0;
    `CHK("take", tk, irq.take)
    if (tk)
      `CHK("vector", {gen, vec}, {irq.general, gen ? vec : irq.vec})
  endtask
  // ----------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------
  task automatic t_serial();
    pulse_sim(8'h40);
    `CHK("sod low", 1'b0, serial_out_line)
    pulse_sim(8'h80);
    `CHK("sod kept", 1'b0, serial_out_line)
    for (int v = 1; v >= 0; v--)
    begin
      serial_in_line = v[0];
      repeat (4) @(negedge ref_clk);
      read_mask_instruction = 1'b1;
      @(negedge ref_clk);
      read_mask_instruction = 1'b0;
      @(negedge ref_clk);
      `CHK("sid bit", v[0], rim_data[7])
      `CHK("masks", CBSC_MASK_RST, rim_data[2:0])
    end
    $display("test serial done");
  endtask
  task automatic t_pin_reset();
    rst_in_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    `WAIT_FOR(reset_out === 1'b1, 6)
    `CHK("reset out", 1'b1, reset_out)
    `CHK("grant", 1'b0, grant)
    rst_in_n = 1'b1;
    `WAIT_FOR(reset_out === 1'b0, 8)
    `CHK("reset end", 1'b0, reset_out)
    `CHK("sod high", 1'b1, serial_out_line)
    $display("test pin reset done");
  endtask
  task automatic t_cycles();
    bus_op(CBSC_K_WRITE, 1'b0, 16'h12A5, 8'hC3, 1'b0, 8'h00);
    bus_op(CBSC_K_READ, 1'b0, 16'h12A5, 8'h00, 1'b0, 8'hC3);
    bus_op(CBSC_K_WRITE, 1'b1, 16'h4747, 8'h3C, 1'b0, 8'h00);
    bus_op(CBSC_K_READ, 1'b1, 16'h4747, 8'h00, 1'b0, 8'h3C);
    bus_op(CBSC_K_FETCH, 1'b0, 16'hFF10, 8'h00, 1'b0, 8'h4A);
    bus_op(CBSC_K_IDLE, 1'b0, 16'h0000, 8'h00, 1'b0, 8'h00);
    mem_wait = 4'h3;
    repeat (2) @(negedge ref_clk);
    bus_op(CBSC_K_READ, 1'b0, 16'h12A5, 8'h00, 1'b0, 8'hC3);
    bus_op(CBSC_K_FETCH, 1'b0, 16'h0033, 8'h00, 1'b0, 8'h69);
    mem_wait = 4'h0;
    $display("test cycles done");
  endtask
  task automatic t_hold();
    logic [7:0] up;
    core_req = '{1'b1, CBSC_K_READ, 1'b0, 16'h12A5, 8'h00};
    @(negedge ref_clk);
    `WAIT_FOR(taken === 1'b1, 20)
    core_req.valid = 1'b0;
    hold           = 1'b1;
    n              = 0;
    while (done !== 1'b1 && n < 40)
    begin
      `CHK("early grant", 1'b0, grant)
      @(negedge ref_clk);
      n++;
    end
    `WAIT_FOR(grant === 1'b1, 8)
    `CHK("grant", 1'b1, grant)
    up = upper;
    core_req.valid = 1'b1;
    @(negedge ref_clk);
    `CHK("released", 2'b00, {ctl_oe, bus_oe})
    repeat (5)
    begin
      @(negedge ref_clk);
      `CHK("no take", 1'b0, taken)
      `CHK("kept upper", up, upper)
    end
    core_req.valid = 1'b0;
    hold           = 1'b0;
    `WAIT_FOR(grant === 1'b0, 8)
    `CHK("grant end", 2'b00, {grant, ctl_oe})
    @(negedge ref_clk);
    `CHK("resumed", 1'b1, ctl_oe)
    bus_op(CBSC_K_READ, 1'b1, 16'h0047, 8'h00, 1'b0, 8'h3C);
    $display("test hold done");
  endtask
  task automatic t_irq();
    pulse_sim(8'h08);
    {trap, irq_edge, irq_mid, irq_low, gen_irq} = 5'h1F;
    irq_step(1'b1, 1'b1, CBSC_VEC_TRAP, 1'b0);
    irq_edge = 1'b0;
    irq_step(1'b1, 1'b1, CBSC_VEC_EDGE, 1'b0);
    irq_step(1'b1, 1'b1, CBSC_VEC_MID, 1'b0);
    irq_mid = 1'b0;
    irq_step(1'b1, 1'b1, CBSC_VEC_LOW, 1'b0);
    irq_low = 1'b0;
    ei = 1'b1;
    @(negedge ref_clk);
    {ei, di} = 2'b01;
    @(negedge ref_clk);
    di = 1'b0;
    irq_step(1'b0, 1'b0, 8'h00, 1'b0);
    irq_step(1'b1, 1'b1, 8'h00, 1'b1);
    gen_irq = 1'b0;
    bus_op(CBSC_K_READ, 1'b0, 16'h2000, 8'h00, 1'b1, 8'h5A);
    trap = 1'b0;
    irq_edge = 1'b1;
    repeat (4) @(negedge ref_clk);
    pulse_sim(8'h18);
    irq_edge = 1'b0;
    irq_step(1'b1, 1'b0, 8'h00, 1'b0);
    $display("test interrupts done");
  endtask
  task automatic t_power();
    repeat (3) @(negedge ref_clk);
    halt = 1'b1;
    @(negedge ref_clk);
    halt = 1'b0;
    `WAIT_FOR(pwr_down === 1'b1, 6)
    repeat (4) @(negedge ref_clk);
    `CHK("asleep", 3'b100, {pwr_down, st_h, st_l})
    irq_low = 1'b1;
    `WAIT_FOR(pwr_down === 1'b0, 8)
    `CHK("woken", 1'b0, pwr_down)
    irq_low = 1'b0;
    $display("test power down done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A hang counts as a mismatch and still reaches the report.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    repeat (16) @(negedge ref_clk);
    `CHK("reset pins", 6'b110110, {reset_out, serial_out_line, grant, read_n, write_n, pwr_down})
    srst = 1'b0;
    `WAIT_FOR(reset_out === 1'b0, 8)
    t_serial();
    t_pin_reset();
    t_cycles();
    t_hold();
    t_irq();
    t_power();
    conclude();
  end
endmodule
